/* File: src/voltage_limit_power_good.sv */
// Top: Wishbone register file, limit responses and power-good pin control
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ps
module voltage_limit_power_good #(
   parameter int unsigned TICK_CYCLES = vlpg_pkg::TICK_CYCLES_DEF
) (
   input  wire logic                          sys_clk,
   input  wire logic                          rst,
   input  wire logic                          wb_cyc_i,
   input  wire logic                          wb_stb_i,
   input  wire logic                          wb_we_i,
   input  wire logic [7:0]                    wb_adr_i,
   input  wire logic [3:0]                    wb_sel_i,
   input  wire logic [31:0]                   wb_dat_i,
   output logic      [31:0]                   wb_dat_o,
   output logic                               wb_ack_o,
   input  wire logic                          sample_valid,
   input  wire logic [vlpg_pkg::SAMPLE_W-1:0] sample_data,
   input  wire logic                          strap_sense_high,
   input  wire logic                          strap_sense_low,
   input  wire logic                          output_sense_input,
   output logic                               power_good_pin_o,
   output logic                               power_good_pin_oe_n,
   output logic                               alert_pin_o,
   output logic                               alert_pin_oe_n,
   output logic                               channel_off
);
   import vlpg_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Storage
   logic [7:0]          uv_warn_high_bits_reg;
   logic [1:0]          uv_warn_low_bits_reg;
   logic [7:0]          uv_crit_high_bits_reg;
   logic [1:0]          uv_crit_low_bits_reg;
   logic [7:0]          ov_warn_high_bits_reg;
   logic [1:0]          ov_warn_low_bits_reg;
   logic [7:0]          ov_crit_high_bits_reg;
   logic [1:0]          ov_crit_low_bits_reg;
   logic [1:0]          good_delay_code_reg;
   logic [SAMPLE_W-1:0] sample_reg;
   logic                alert_reg;
   logic                shutdown_reg;
   logic                good_reg;
   logic                ack_reg;
   logic [31:0]         dat_reg;
   logic                good_oe_n_reg;
   logic                alert_oe_n_reg;
   logic                pin_low_reg;
   logic [1:0]          sense_sync_reg;
   logic [1:0]          strap_hi_sync_reg;
   logic [1:0]          strap_lo_sync_reg;
   resp_e               resp_code_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Wishbone decode: one word per register, index from address bits 7:2
   wire logic [IDX_W-1:0] idx = wb_adr_i[7:2];
   wire req      = wb_cyc_i && wb_stb_i && !ack_reg;
   wire wr_en    = req && wb_we_i && wb_sel_i[0];
   wire [7:0] wd = wb_dat_i[7:0];

   wire hit_uv_warn_hi = idx == IDX_UV_WARN_HI;
   wire hit_uv_warn_lo = idx == IDX_UV_WARN_LO;
   wire hit_uv_crit_hi = idx == IDX_UV_CRIT_HI;
   wire hit_uv_crit_lo = idx == IDX_UV_CRIT_LO;
   wire hit_ov_warn_hi = idx == IDX_OV_WARN_HI;
   wire hit_ov_warn_lo = idx == IDX_OV_WARN_LO;
   wire hit_ov_crit_hi = idx == IDX_OV_CRIT_HI;
   wire hit_ov_crit_lo = idx == IDX_OV_CRIT_LO;
   wire hit_status     = idx == IDX_STATUS;
   wire hit_delay      = idx == IDX_DELAY;

   wire sense_level = sense_sync_reg[1];

   // Read values; unmapped indices and unused bits read zero
   wire [7:0] rd_uv_warn_lo = {6'h00, uv_warn_low_bits_reg};
   wire [7:0] rd_uv_crit_lo = {6'h00, uv_crit_low_bits_reg};
   wire [7:0] rd_ov_warn_lo = {6'h00, ov_warn_low_bits_reg};
   wire [7:0] rd_ov_crit_lo = {6'h00, ov_crit_low_bits_reg};
   wire [7:0] rd_delay      = {6'h00, good_delay_code_reg};
   wire [7:0] rd_status     = {2'h0, sense_level, alert_reg, 3'h0, good_reg};

   wire [7:0] rd_byte =
      ({8{hit_uv_warn_hi}} & uv_warn_high_bits_reg) |
      ({8{hit_uv_warn_lo}} & rd_uv_warn_lo) |
      ({8{hit_uv_crit_hi}} & uv_crit_high_bits_reg) |
      ({8{hit_uv_crit_lo}} & rd_uv_crit_lo) |
      ({8{hit_ov_warn_hi}} & ov_warn_high_bits_reg) |
      ({8{hit_ov_warn_lo}} & rd_ov_warn_lo) |
      ({8{hit_ov_crit_hi}} & ov_crit_high_bits_reg) |
      ({8{hit_ov_crit_lo}} & rd_ov_crit_lo) |
      ({8{hit_status}}     & rd_status) |
      ({8{hit_delay}}      & rd_delay);

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h0000_0000;
      end else begin
         ack_reg <= req;
         dat_reg <= req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Limit registers
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         uv_warn_high_bits_reg <= RST_UV_HI;
         uv_warn_low_bits_reg  <= RST_UV_LO;
         uv_crit_high_bits_reg <= RST_UV_HI;
         uv_crit_low_bits_reg  <= RST_UV_LO;
         ov_warn_high_bits_reg <= RST_OV_HI;
         ov_warn_low_bits_reg  <= RST_OV_LO;
         ov_crit_high_bits_reg <= RST_OV_HI;
         ov_crit_low_bits_reg  <= RST_OV_LO;
      end else if (wr_en) begin
         if (hit_uv_warn_hi) uv_warn_high_bits_reg <= wd;
         if (hit_uv_warn_lo) uv_warn_low_bits_reg  <= wd[1:0];
         if (hit_uv_crit_hi) uv_crit_high_bits_reg <= wd;
         if (hit_uv_crit_lo) uv_crit_low_bits_reg  <= wd[1:0];
         if (hit_ov_warn_hi) ov_warn_high_bits_reg <= wd;
         if (hit_ov_warn_lo) ov_warn_low_bits_reg  <= wd[1:0];
         if (hit_ov_crit_hi) ov_crit_high_bits_reg <= wd;
         if (hit_ov_crit_lo) ov_crit_low_bits_reg  <= wd[1:0];
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         good_delay_code_reg <= RST_DELAY_CODE;
      end else if (wr_en && hit_delay) begin
         good_delay_code_reg <= wd[DELAY_CODE_LSB +: 2];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Latest conversion, from logic in this clock domain
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sample_reg <= '0;
      end else if (sample_valid) begin
         sample_reg <= sample_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sense_sync_reg    <= 2'h0;
         strap_hi_sync_reg <= 2'h0;
         // Strap reads as low until sensed, so shutdown stays the response
         strap_lo_sync_reg <= 2'h3;
      end else begin
         sense_sync_reg    <= {sense_sync_reg[0], output_sense_input};
         strap_hi_sync_reg <= {strap_hi_sync_reg[0], strap_sense_high};
         strap_lo_sync_reg <= {strap_lo_sync_reg[0], strap_sense_low};
      end
   end

   // Both sensed at once is read as low: the safest response wins
   wire strap_hi = strap_hi_sync_reg[1];
   wire strap_lo = strap_lo_sync_reg[1];
   wire resp_e resp_next = strap_lo ? RESP_SHUTDOWN :
                           strap_hi ? RESP_CLEAR_GOOD : RESP_ALERT_ONLY;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         resp_code_reg <= RESP_SHUTDOWN;
      end else begin
         resp_code_reg <= resp_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Comparators
   limit_cmp_if cmp ();

   assign cmp.sample          = sample_reg;
   assign cmp.low_warn_limit  = {uv_warn_high_bits_reg, uv_warn_low_bits_reg};
   assign cmp.low_crit_limit  = {uv_crit_high_bits_reg, uv_crit_low_bits_reg};
   assign cmp.high_warn_limit = {ov_warn_high_bits_reg, ov_warn_low_bits_reg};
   assign cmp.high_crit_limit = {ov_crit_high_bits_reg, ov_crit_low_bits_reg};

   limit_compare u_compare (
      .sys_clk (sys_clk),
      .rst     (rst),
      .cmp     (cmp.comparator)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Responses
   wire warn_hit   = cmp.low_warn_hit || cmp.high_warn_hit;
   wire crit_hit   = cmp.low_crit_hit || cmp.high_crit_hit;
   wire warn_event = warn_hit && good_reg;
   wire alert_set  = warn_event || crit_hit;
   wire stat_wr    = wr_en && hit_status;
   wire alert_clr  = stat_wr && wd[STAT_ALERT_BIT];
   wire shut_set   = crit_hit && (resp_code_reg == RESP_SHUTDOWN);
   wire in_window  = !crit_hit;
   // Alert-only response keeps an already asserted good through a critical hit
   wire hold_good  = (resp_code_reg == RESP_ALERT_ONLY) && good_reg;
   wire qualify    = (in_window || hold_good) && !shutdown_reg;
   wire timer_good;

   good_delay_timer #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_timer (
      .sys_clk      (sys_clk),
      .rst          (rst),
      .qualify      (qualify),
      .delay_code   (good_delay_code_reg),
      .delayed_good (timer_good)
   );

   // Gating with qualify drops good in the same cycle the window is left
   wire good_next  = timer_good && qualify;
   wire alert_next = alert_set || (alert_reg && !alert_clr);
   // Open-drain pin is pulled low while good in low-active sense, else while not good
   wire pin_low_next = sense_level ? !good_next : good_next;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         alert_reg    <= 1'b0;
         shutdown_reg <= 1'b0;
         good_reg     <= 1'b0;
      end else begin
         alert_reg    <= alert_next;
         // Shutdown latches; the alert clear releases it once the fault is gone
         shutdown_reg <= shut_set || (shutdown_reg && !alert_clr);
         good_reg     <= good_next;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pin_low_reg    <= 1'b0;
         good_oe_n_reg  <= 1'b1;
         alert_oe_n_reg <= 1'b1;
      end else begin
         pin_low_reg    <= 1'b0;
         good_oe_n_reg  <= !pin_low_next;
         alert_oe_n_reg <= !alert_next;
      end
   end

   assign power_good_pin_o    = pin_low_reg;
   assign power_good_pin_oe_n = good_oe_n_reg;
   assign alert_pin_o         = pin_low_reg;
   assign alert_pin_oe_n      = alert_oe_n_reg;
   assign channel_off         = shutdown_reg;
endmodule : voltage_limit_power_good

/* File: src/vlpg_pkg.sv */
// Constants, register map and types for the voltage limit and power-good block
// Summary of operation
// - Low-warning limit bits 1:0 in own register
// - Low-critical limit: ten bits, split, reset zero
// - High-warning limit: ten bits, resets all ones
// - High-critical limit: ten bits, resets all ones
// - Warning alerts; critical response follows code
// - Strap low/high/open gives code 00/01/10
// - Good only inside the critical window, unless alert-only code holds it
// - Status bit 0 shows good, polarity-free
// - Sense input selects power-good pin polarity
// - Sense mirrored in bit 5, live polarity
// - Assertion delay 50/100/200/400 ms by code
// - Delay code bits 1:0, upper bits zero
// - Latest sample compared against four limits
// - Strap changes only critical responses
// - Warning alerts only while good asserted
package vlpg_pkg;
   ////////////////////////////////////////////////////////////////////////////////
   localparam int          SAMPLE_W        = 10;
   localparam int          IDX_W           = 6;
   // Register indices; byte address is four times the index
   localparam logic [5:0]  IDX_UV_WARN_HI  = 6'h1A;
   localparam logic [5:0]  IDX_UV_WARN_LO  = 6'h1B;
   localparam logic [5:0]  IDX_UV_CRIT_HI  = 6'h1C;
   localparam logic [5:0]  IDX_UV_CRIT_LO  = 6'h1D;
   localparam logic [5:0]  IDX_OV_WARN_HI  = 6'h1E;
   localparam logic [5:0]  IDX_OV_WARN_LO  = 6'h1F;
   localparam logic [5:0]  IDX_OV_CRIT_HI  = 6'h20;
   localparam logic [5:0]  IDX_OV_CRIT_LO  = 6'h21;
   localparam logic [5:0]  IDX_STATUS      = 6'h34;
   localparam logic [5:0]  IDX_DELAY       = 6'h38;
   ////////////////////////////////////////////////////////////////////////////////
   localparam logic [7:0]  RST_UV_HI       = 8'h00;
   localparam logic [1:0]  RST_UV_LO       = 2'h0;
   localparam logic [7:0]  RST_OV_HI       = 8'hFF;
   localparam logic [1:0]  RST_OV_LO       = 2'h3;
   localparam logic [1:0]  RST_DELAY_CODE  = 2'h0;
   // Field positions
   localparam int          STAT_GOOD_BIT   = 0;
   localparam int          STAT_ALERT_BIT  = 4;
   localparam int          STAT_SENSE_BIT  = 5;
   localparam int          DELAY_CODE_LSB  = 0;
   ////////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int          CLK_HZ          = 125_000_000;
   localparam int          TICK_MS         = 1;
   localparam int          TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;
   localparam int          DELAY_MS_W      = 9;
   localparam logic [8:0]  DELAY_MS_CODE0  = 9'd50;
   localparam logic [8:0]  DELAY_MS_CODE1  = 9'd100;
   localparam logic [8:0]  DELAY_MS_CODE2  = 9'd200;
   localparam logic [8:0]  DELAY_MS_CODE3  = 9'd400;
   ////////////////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {
      RESP_SHUTDOWN   = 2'b00,
      RESP_CLEAR_GOOD = 2'b01,
      RESP_ALERT_ONLY = 2'b10
   } resp_e;

   typedef enum logic [1:0] {
      TMR_IDLE  = 2'b00,
      TMR_COUNT = 2'b01,
      TMR_GOOD  = 2'b10
   } tmr_state_e;
endpackage : vlpg_pkg

/* File: src/limit_cmp_if.sv */
// Interface carrying the sample, the four limits and the compare results
`timescale 1ns/1ps
interface limit_cmp_if;
   logic [vlpg_pkg::SAMPLE_W-1:0] sample;
   logic [vlpg_pkg::SAMPLE_W-1:0] low_warn_limit;
   logic [vlpg_pkg::SAMPLE_W-1:0] low_crit_limit;
   logic [vlpg_pkg::SAMPLE_W-1:0] high_warn_limit;
   logic [vlpg_pkg::SAMPLE_W-1:0] high_crit_limit;
   logic                          low_warn_hit;
   logic                          low_crit_hit;
   logic                          high_warn_hit;
   logic                          high_crit_hit;

   modport comparator (
      input  sample,
      input  low_warn_limit,
      input  low_crit_limit,
      input  high_warn_limit,
      input  high_crit_limit,
      output low_warn_hit,
      output low_crit_hit,
      output high_warn_hit,
      output high_crit_hit
   );

   modport control (
      output sample,
      output low_warn_limit,
      output low_crit_limit,
      output high_warn_limit,
      output high_crit_limit,
      input  low_warn_hit,
      input  low_crit_hit,
      input  high_warn_hit,
      input  high_crit_hit
   );
endinterface : limit_cmp_if

/* File: src/limit_compare.sv */
// Registered comparison of the latest sample against four limits
`timescale 1ns/1ps
module limit_compare (
   input  wire logic          sys_clk,
   input  wire logic          rst,
   limit_cmp_if.comparator    cmp
);
   import vlpg_pkg::*;

   // Strict compares, so reset limits of zero and all ones never flag
   wire low_warn_now  = cmp.sample < cmp.low_warn_limit;
   wire low_crit_now  = cmp.sample < cmp.low_crit_limit;
   wire high_warn_now = cmp.sample > cmp.high_warn_limit;
   wire high_crit_now = cmp.sample > cmp.high_crit_limit;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cmp.low_warn_hit  <= 1'b0;
         cmp.low_crit_hit  <= 1'b0;
         cmp.high_warn_hit <= 1'b0;
         cmp.high_crit_hit <= 1'b0;
      end else begin
         cmp.low_warn_hit  <= low_warn_now;
         cmp.low_crit_hit  <= low_crit_now;
         cmp.high_warn_hit <= high_warn_now;
         cmp.high_crit_hit <= high_crit_now;
      end
   end
endmodule : limit_compare

/* File: src/good_delay_timer.sv */
// Power-good assertion delay timer with a millisecond tick divider
`timescale 1ns/1ps
module good_delay_timer #(
   parameter int unsigned TICK_CYCLES = vlpg_pkg::TICK_CYCLES_DEF
) (
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       qualify,
   input  wire logic [1:0] delay_code,
   output logic            delayed_good
);
   import vlpg_pkg::*;

   localparam int TW = $clog2(TICK_CYCLES + 1);

   if (TICK_CYCLES < 1) begin : g_bad_tick
      $error("TICK_CYCLES must be at least one");
   end

   tmr_state_e          state_reg;
   logic [TW-1:0]       div_reg;
   logic [DELAY_MS_W-1:0] ms_reg;

   wire logic [DELAY_MS_W-1:0] target_ms =
      (delay_code == 2'h0) ? DELAY_MS_CODE0 :
      (delay_code == 2'h1) ? DELAY_MS_CODE1 :
      (delay_code == 2'h2) ? DELAY_MS_CODE2 : DELAY_MS_CODE3;
   wire tick    = div_reg == TW'(TICK_CYCLES - 1);
   wire ms_done = tick && (ms_reg == target_ms - 9'd1);

   assign delayed_good = state_reg == TMR_GOOD;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_reg <= TMR_IDLE;
         div_reg   <= '0;
         ms_reg    <= '0;
      end else begin
         case (state_reg)
            TMR_IDLE: begin
               div_reg <= '0;
               ms_reg  <= '0;
               if (qualify) begin
                  state_reg <= TMR_COUNT;
               end
            end
            TMR_COUNT: begin
               // Leaving the window restarts the whole delay
               if (!qualify) begin
                  state_reg <= TMR_IDLE;
               end else if (ms_done) begin
                  state_reg <= TMR_GOOD;
               end else if (tick) begin
                  div_reg <= '0;
                  ms_reg  <= ms_reg + 9'd1;
               end else begin
                  div_reg <= div_reg + TW'(1);
               end
            end
            TMR_GOOD: begin
               if (!qualify) begin
                  state_reg <= TMR_IDLE;
               end
            end
            default: begin
               state_reg <= TMR_IDLE;
            end
         endcase
      end
   end
endmodule : good_delay_timer

/* File: test/vlpg_host.sv */
// Host-side model that resolves the open-drain pins it watches
`timescale 1ns/1ps
module vlpg_host (
   input  wire logic pwr_o,
   input  wire logic pwr_oe_n,
   input  wire logic al_o,
   input  wire logic al_oe_n,
   input  wire logic sense,
   output logic      pwr_lv,
   output logic      al_lv,
   output logic      good
);
   // Board pull-ups: a released line reads high, never the last driven level
   assign pwr_lv = pwr_oe_n ? 1'b1 : pwr_o;
   assign al_lv  = al_oe_n ? 1'b1 : al_o;
   assign good   = sense ? pwr_lv : !pwr_lv;
endmodule : vlpg_host

/* File: test/vlpg_chk.sv */
// Assertion checker bound to the voltage limit and power-good top
`timescale 1ns/1ps
module vlpg_chk #(
   parameter int unsigned TICK_CYCLES = 1
) (
   input wire logic                          sys_clk,
   input wire logic                          rst,
   input wire logic                          wb_cyc_i,
   input wire logic                          wb_stb_i,
   input wire logic                          wb_we_i,
   input wire logic [7:0]                    wb_adr_i,
   input wire logic [3:0]                    wb_sel_i,
   input wire logic [31:0]                   wb_dat_i,
   input wire logic [31:0]                   wb_dat_o,
   input wire logic                          wb_ack_o,
   input wire logic                          sample_valid,
   input wire logic [vlpg_pkg::SAMPLE_W-1:0] sample_data,
   input wire logic                          strap_sense_high,
   input wire logic                          strap_sense_low,
   input wire logic                          output_sense_input,
   input wire logic                          power_good_pin_o,
   input wire logic                          power_good_pin_oe_n,
   input wire logic                          alert_pin_o,
   input wire logic                          alert_pin_oe_n,
   input wire logic                          channel_off
);
   // Slack of two cycles covers the sample and compare stages
   localparam int GOOD_MIN = 50 * TICK_CYCLES - 2;
   logic        sense_q;
   logic [2:0]  sense_age;
   logic [31:0] ng_cnt;
   wire         good_ind = output_sense_input ? power_good_pin_oe_n : !power_good_pin_oe_n;
   wire         settled  = (sense_age == 3'h7);
   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sense_q   <= 1'b0;
         sense_age <= 3'h0;
         ng_cnt    <= '0;
      end else begin
         sense_q   <= output_sense_input;
         sense_age <= (sense_q != output_sense_input) ? 3'h0 : sense_age + {2'h0, !settled};
         // Wide enough for the full delay at the default tick
         ng_cnt    <= (settled && good_ind) ? '0 : ng_cnt + 32'(ng_cnt != '1);
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   AST_ACK_ONE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing one cycle after request");
   AST_ACK_SINGLE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data not zero outside ack");
   AST_DAT_HI: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   AST_PIN_O: assert property (power_good_pin_o == 1'b0)
      else $error("power good pin data not zero");
   AST_ALERT_O: assert property (alert_pin_o == 1'b0)
      else $error("alert pin data not zero");
   AST_SHUT_NOT_GOOD: assert property (settled && channel_off |=> !good_ind)
      else $error("good shown while channel shut off");
   AST_SHUT_ALERT: assert property ($rose(channel_off) |-> ##[0:1] !alert_pin_oe_n)
      else $error("shutdown without alert");
   AST_GOOD_DELAY: assert property (settled && $rose(good_ind) |-> ng_cnt >= GOOD_MIN)
      else $error("good asserted before its delay");
   AST_SENSE_FLIP: assert property ($changed(output_sense_input)
      |-> ##[1:5] $changed(power_good_pin_oe_n))
      else $error("pin polarity did not follow sense input");
   cover property (channel_off);
   cover property (settled && $rose(good_ind));
   cover property ($fell(alert_pin_oe_n));
endmodule : vlpg_chk

bind voltage_limit_power_good vlpg_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
   .sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sample_valid(sample_valid),
   .sample_data(sample_data), .strap_sense_high(strap_sense_high),
   .strap_sense_low(strap_sense_low), .output_sense_input(output_sense_input),
   .power_good_pin_o(power_good_pin_o), .power_good_pin_oe_n(power_good_pin_oe_n),
   .alert_pin_o(alert_pin_o), .alert_pin_oe_n(alert_pin_oe_n), .channel_off(channel_off));

/* File: test/voltage_limit_power_good_tb.sv */
// Self-checking bench for the voltage limit and power-good block
`timescale 1ns/1ps
module voltage_limit_power_good_tb;
   import vlpg_pkg::*;
   localparam int unsigned TK = 2;
   logic        sys_clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, sv = 0;
   logic        sh = 0, sl = 0, sense = 1;
   logic [7:0]  adr = 0;
   logic [3:0]  sel = 0;
   logic [31:0] wdat = 0, rdat;
   logic [9:0]  sd = 0;
   logic        ack, pwr_o, pwr_oe_n, al_o, al_oe_n, choff, pwr_lv, al_lv, good;
   int          n_fail = 0, tests_run = 0, seed = 32'hFA41C8D4;
   logic [31:0] exp_q[$];
   always #4 sys_clk = ~sys_clk;
   voltage_limit_power_good #(.TICK_CYCLES(TK)) u_dut (
      .sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .sample_valid(sv), .sample_data(sd), .strap_sense_high(sh), .strap_sense_low(sl),
      .output_sense_input(sense), .power_good_pin_o(pwr_o), .power_good_pin_oe_n(pwr_oe_n),
      .alert_pin_o(al_o), .alert_pin_oe_n(al_oe_n), .channel_off(choff));
   vlpg_host u_host (.pwr_o(pwr_o), .pwr_oe_n(pwr_oe_n), .al_o(al_o), .al_oe_n(al_oe_n),
      .sense(sense), .pwr_lv(pwr_lv), .al_lv(al_lv), .good(good));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      // Reads that never got an answer count as mismatches
      n_fail += exp_q.size();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic wb(logic w, logic [5:0] ix, logic [7:0] d, logic [3:0] s = 4'h1);
      int i;
      @(posedge sys_clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= {ix, 2'b00};
      sel  <= s;
      wdat <= {24'h0, d};
      i = 0;
      do begin
         @(posedge sys_clk);
         i++;
      end while (ack !== 1'b1 && i < 20);
      cyc <= 1'b0;
      stb <= 1'b0;
      if (i >= 20) begin
         n_fail++;
         tally_and_finish;
      end
   endtask : wb
   task automatic rd(logic [5:0] ix, logic [7:0] e);
      exp_q.push_back({24'h0, e});
      wb(1'b0, ix, 8'h00);
   endtask : rd
   task automatic samp(logic [9:0] v);
      @(posedge sys_clk);
      sv <= 1'b1;
      sd <= v;
      @(posedge sys_clk);
      sv <= 1'b0;
   endtask : samp
   task automatic wait_good(output int c);
      c = 0;
      while (good !== 1'b1 && c < 4000) begin
         @(posedge sys_clk);
         c++;
      end
      if (c >= 4000) begin
         n_fail++;
         tally_and_finish;
      end
   endtask : wait_good
   // Read data is judged where it appears, against the oldest note
   always @(posedge sys_clk)
      if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
         chk("rd", exp_q.pop_front(), rdat);
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [5:0]  ix [10] = '{IDX_UV_WARN_HI, IDX_UV_WARN_LO, IDX_UV_CRIT_HI, IDX_UV_CRIT_LO,
         IDX_OV_WARN_HI, IDX_OV_WARN_LO, IDX_OV_CRIT_HI, IDX_OV_CRIT_LO, IDX_STATUS, IDX_DELAY};
      logic [7:0]  rv [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h03, 8'hFF, 8'h03, 8'h20, 8'h00};
      logic [7:0]  mk [10] = '{8'hFF, 8'h03, 8'hFF, 8'h03, 8'hFF, 8'h03, 8'hFF, 8'h03, 8'h00, 8'h03};
      logic [7:0]  lv [8]  = '{8'h60, 8'h00, 8'h40, 8'h00, 8'hA0, 8'h00, 8'hC0, 8'h00};
      int          dm [4]  = '{50, 100, 200, 400};
      logic [7:0]  r;
      int          c;
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      for (int i = 0; i < 10; i++) rd(ix[i], rv[i]);
      rd(6'h3F, 8'h00);
      for (int i = 0; i < 10; i++) begin
         r = 8'($random(seed));
         if (i != 8) wb(1'b1, ix[i], r);
         if (i != 8) rd(ix[i], r & mk[i]);
      end
      for (int i = 0; i < 8; i++) wb(1'b1, ix[i], lv[i]);
      wb(1'b1, IDX_UV_CRIT_HI, 8'h5A, 4'h0);
      rd(IDX_UV_CRIT_HI, 8'h40);
      sh <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         wb(1'b1, IDX_DELAY, 8'(i));
         samp(10'h050);
         repeat (4) @(posedge sys_clk);
         chk("good_off", 0, good);
         samp(10'h200);
         wait_good(c);
         chk("delay", 1, c >= dm[i] * TK - 2 && c <= dm[i] * TK + 6);
      end
      rd(IDX_STATUS, 8'h31);
      wb(1'b1, IDX_STATUS, 8'h10);
      rd(IDX_STATUS, 8'h21);
      sense <= 1'b0;
      repeat (5) @(posedge sys_clk);
      chk("pwr_lv", 0, pwr_lv);
      rd(IDX_STATUS, 8'h01);
      sense <= 1'b1;
      samp(10'h150);
      repeat (4) @(posedge sys_clk);
      chk("al_warn", 0, al_lv);
      chk("good_warn", 1, good);
      samp(10'h050);
      samp(10'h150);
      repeat (3) @(posedge sys_clk);
      wb(1'b1, IDX_STATUS, 8'h10);
      repeat (5) @(posedge sys_clk);
      chk("al_nogood", 1, al_lv);
      wb(1'b1, IDX_DELAY, 8'h00);
      for (int j = 0; j < 3; j++) begin
         sl <= (j == 0);
         sh <= (j == 1);
         samp(10'h200);
         wait_good(c);
         samp(10'h350);
         repeat (5) @(posedge sys_clk);
         chk("choff", j == 0, choff);
         chk("good_crit", j == 2, good);
         chk("al_crit", 0, al_lv);
         samp(10'h200);
         repeat (3) @(posedge sys_clk);
         wb(1'b1, IDX_STATUS, 8'h10);
         repeat (3) @(posedge sys_clk);
         chk("choff_clr", 0, choff);
      end
      tally_and_finish;
   end
endmodule : voltage_limit_power_good_tb
